/* verilog/dmlc_defines.svh */
/*
 * constants for the loop mode and control register bank: register indices,
 * field positions, reset values and timing figures.
 * assumes: included by bare name from the design modules.
 */
`ifndef DMLC_DEFINES_SVH
`define DMLC_DEFINES_SVH

// register indices; the byte address on the bus is four times the index
`define DMLC_IDX_LOOP        8'h1D
`define DMLC_IDX_HOLD        8'h1E
`define DMLC_IDX_MODE        8'h1F
`define DMLC_IDX_REFSEL      8'h20

// reset values
`define DMLC_RST_LOOP        8'h3C
`define DMLC_RST_HOLD        8'h04
`define DMLC_RST_MODE        3'h3
`define DMLC_RST_REFSEL      4'h0

// field positions
`define DMLC_F_HITLESS       0
`define DMLC_F_BW_LO         1
`define DMLC_F_BW_HI         3
`define DMLC_F_SLOPE_LO      4
`define DMLC_F_SLOPE_HI      5
`define DMLC_F_REVERT        0
`define DMLC_F_FOFS          1
`define DMLC_F_HUPD_LO       4
`define DMLC_F_HUPD_HI       5
`define DMLC_F_HFILT_LO      6
`define DMLC_F_HFILT_HI      7

// mode and bandwidth codes
`define DMLC_MODE_MAN_NORM   3'h0
`define DMLC_MODE_MAN_HOLD   3'h1
`define DMLC_MODE_MAN_FREE   3'h2
`define DMLC_MODE_AUTO       3'h3
`define DMLC_MODE_PKT_CLIENT 3'h4
`define DMLC_BW_28HZ         3'h4
`define DMLC_BW_890HZ        3'h5
`define DMLC_NUM_REFS        3

// holdover refresh periods, in ms, and the clock rate in kHz
`define DMLC_CLK_KHZ         125000
`define DMLC_HOLD_T0_MS      26
`define DMLC_HOLD_T1_MS      1000
`define DMLC_HOLD_T2_MS      10000
`define DMLC_HOLD_T3_MS      60000

`endif

/* verilog/dmlc_pkg.sv */
/*
 * types of the loop mode and control block: loop state and effective
 * loop bandwidth codes.
 * assumes: nothing beyond the defines header.
 */
package dmlc_pkg;
    // loop state, one-hot
    typedef enum logic [3:0] {
        DMLC_ST_LOCKED = 4'b0001,
        DMLC_ST_HOLD   = 4'b0010,
        DMLC_ST_FREE   = 4'b0100,
        DMLC_ST_SWCL   = 4'b1000
    } dmlc_state_t;

    // bandwidth actually applied; codes 0..6 equal the register codes
    typedef enum logic [3:0] {
        DMLC_EBW_0HZ1  = 4'h0,
        DMLC_EBW_1HZ7  = 4'h1,
        DMLC_EBW_3HZ5  = 4'h2,
        DMLC_EBW_14HZ  = 4'h3,
        DMLC_EBW_28HZ  = 4'h4,
        DMLC_EBW_890HZ = 4'h5,
        DMLC_EBW_FAST  = 4'h6,
        DMLC_EBW_56HZ  = 4'h7,
        DMLC_EBW_RSVD  = 4'hF
    } dmlc_bw_t;
endpackage : dmlc_pkg

/* verilog/dmlc_hold_timer.sv */
/*
 * holdover refresh timer: gives a one-cycle tick each time the selected
 * update period has elapsed while the loop is tracking a reference.
 * assumes: one clock, clock enable freezes the count.
 */
`include "dmlc_defines.svh"

module dmlc_hold_timer #(
    parameter longint unsigned CYC0 = 64'd3250000,
    parameter longint unsigned CYC1 = 64'd125000000,
    parameter longint unsigned CYC2 = 64'd1250000000,
    parameter longint unsigned CYC3 = 64'd7500000000
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    // control
    input  wire logic       run,
    input  wire logic [1:0] sel,
    // result
    output logic            tick
);
    localparam longint unsigned LIMIT = 64'h0000000FFFFFFFFF;

    // refused at elaboration: a zero period never ticks, a huge one overflows the count
    if (CYC0 < 1 || CYC1 < 1 || CYC2 < 1 || CYC3 < 1 ||
        CYC0 > LIMIT || CYC1 > LIMIT || CYC2 > LIMIT || CYC3 > LIMIT) begin : g_bad_period
        $error("dmlc_hold_timer: period out of range");
    end

    logic [35:0] cnt;
    logic [35:0] period;

    // period picked from the update field
    always_comb begin
        unique case (sel)
            2'h0: period = CYC0[35:0];
            2'h1: period = CYC1[35:0];
            2'h2: period = CYC2[35:0];
            2'h3: period = CYC3[35:0];
        endcase
    end

    // count restarts whenever tracking stops, so a stale refresh never fires
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 36'h0;
            tick <= 1'b0;
        end else if (clk_en) begin
            if (!run) begin
                cnt  <= 36'h0;
                tick <= 1'b0;
            end else if (cnt >= period - 36'h1) begin
                cnt  <= 36'h0;
                tick <= 1'b1;
            end else begin
                cnt  <= cnt + 36'h1;
                tick <= 1'b0;
            end
        end
    end
endmodule : dmlc_hold_timer

/* verilog/dmlc_top.sv */
/*
 * loop mode and control register bank for a digital phase-locked loop:
 * APB register slave, loop state control, reference choice, bandwidth
 * clamping and holdover refresh timing.
 * assumes: reference qualification and reference rate flags come from
 * monitors outside, synchronous to pclk; lower reference index has the
 * higher priority.
 */
// The APB interface to the registers was left to the implementer.
`include "dmlc_defines.svh"

// Function
// - bandwidth field bits 3:1, reset fast lock
// - 28 Hz clamps to 14 Hz at 2 kHz
// - 890 Hz clamps to 14/56 Hz
// - phase slope limit bits 5:4, reset unlimited
// - bit 0 enables revertive switching
// - bit 1 enables free-run frequency offset
// - holdover update period bits 5:4
// - holdover post-filter bandwidth bits 7:6
// - manual normal locks to software-chosen reference
// - manual normal: chosen reference fails, holdover
// - manual holdover mode stays in holdover
// - manual free-run mode stays free-running
// - automatic mode locks highest-priority qualified reference
// - automatic mode switches when reference fails
// - automatic mode: none available, holdover
// - packet client mode hands oscillator to software
// - bit 0 chooses phase build-out or realign
// - reference select: written manual, reported automatic
module dmlc_top
    import dmlc_pkg::*;
#(
    parameter longint unsigned HOLD_CYC0 = 64'(`DMLC_HOLD_T0_MS) * `DMLC_CLK_KHZ,
    parameter longint unsigned HOLD_CYC1 = 64'(`DMLC_HOLD_T1_MS) * `DMLC_CLK_KHZ,
    parameter longint unsigned HOLD_CYC2 = 64'(`DMLC_HOLD_T2_MS) * `DMLC_CLK_KHZ,
    parameter longint unsigned HOLD_CYC3 = 64'(`DMLC_HOLD_T3_MS) * `DMLC_CLK_KHZ
) (
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // reference monitor side
    input  wire logic [2:0]  ref_qualified,
    input  wire logic [2:0]  ref_is_2khz,
    input  wire logic [2:0]  ref_is_8khz,
    // loop control outputs
    output dmlc_state_t      loop_state,
    output dmlc_bw_t         loop_bw_eff,
    output logic      [1:0]  phase_slope_limit_sel,
    output logic             hitless_switch_ctrl,
    output logic             revert_en,
    output logic             freq_offset_en,
    output logic      [1:0]  holdover_postfilter_bw,
    output logic             holdover_update,
    output logic             auto_switch_en,
    output logic             dco_sw_ctrl,
    output logic      [1:0]  active_ref,
    output logic             active_valid,
    output logic             switch_start
);
    // the priority encoder and the 2-bit reference index serve exactly three sources
    if (`DMLC_NUM_REFS != 3) begin : g_bad_refs
        $error("dmlc_top: reference count must be 3");
    end

    logic [7:0]  dpll_loop_control;
    logic [7:0]  dpll_holdover_switch_control;
    logic [2:0]  dpll_operating_mode_select;
    logic [3:0]  ref_select;
    logic [7:0]  reg_idx;
    logic        mapped;
    logic        wr_fire;
    logic [7:0]  rd_byte;
    logic [1:0]  best_ref;
    logic        any_qual;
    dmlc_state_t next_state;
    dmlc_bw_t    next_bw;
    logic [1:0]  next_ref;
    logic        next_valid;
    logic        act_2k;
    logic        act_8k;

    // true when a reference code names an existing, qualified reference
    function automatic logic ref_ok(input logic [2:0] q, input logic [3:0] code);
        ref_ok = (code < 4'(`DMLC_NUM_REFS)) && q[code[1:0]];
    endfunction : ref_ok

    // APB decode: zero wait states, frozen with the clock enable
    assign reg_idx = paddr[9:2];
    assign mapped  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                     (reg_idx >= `DMLC_IDX_LOOP) && (reg_idx <= `DMLC_IDX_REFSEL);
    assign pready  = clk_en;
    assign pslverr = psel && penable && !mapped;
    assign wr_fire = clk_en && psel && penable && pwrite && mapped;

    // register write side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dpll_loop_control            <= `DMLC_RST_LOOP;
            dpll_holdover_switch_control <= `DMLC_RST_HOLD;
            dpll_operating_mode_select   <= `DMLC_RST_MODE;
            ref_select                   <= `DMLC_RST_REFSEL;
        end else if (wr_fire) begin
            unique case (reg_idx)
                `DMLC_IDX_LOOP:   dpll_loop_control <= {2'h0, pwdata[5:0]};
                `DMLC_IDX_HOLD:   dpll_holdover_switch_control <= pwdata[7:0];
                `DMLC_IDX_MODE:   dpll_operating_mode_select <= pwdata[2:0];
                // only manual normal takes a written reference
                `DMLC_IDX_REFSEL: if (dpll_operating_mode_select == `DMLC_MODE_MAN_NORM) begin
                    ref_select <= pwdata[3:0];
                end
                default: ;
            endcase
        end
    end

    // read mux; in automatic mode the select register reports the live choice
    always_comb begin
        unique case (reg_idx)
            `DMLC_IDX_LOOP:   rd_byte = dpll_loop_control;
            `DMLC_IDX_HOLD:   rd_byte = dpll_holdover_switch_control;
            `DMLC_IDX_MODE:   rd_byte = {5'h00, dpll_operating_mode_select};
            `DMLC_IDX_REFSEL: rd_byte = (dpll_operating_mode_select == `DMLC_MODE_AUTO) ?
                                        {6'h00, active_ref} : {4'h0, ref_select};
            default:          rd_byte = 8'h00;
        endcase
    end

    // read data captured in the setup cycle so it leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (clk_en && psel && !penable) begin
            prdata <= (mapped && !pwrite) ? {24'h0, rd_byte} : 32'h0;
        end
    end

    // highest-priority qualified reference: lowest index wins
    always_comb begin
        any_qual = |ref_qualified;
        best_ref = 2'h0;
        if (ref_qualified[0]) begin
            best_ref = 2'h0;
        end else if (ref_qualified[1]) begin
            best_ref = 2'h1;
        end else if (ref_qualified[2]) begin
            best_ref = 2'h2;
        end
    end

    // reference choice and next loop state by mode
    always_comb begin
        next_ref   = active_ref;
        next_valid = active_valid;
        next_state = loop_state;
        unique case (dpll_operating_mode_select)
            `DMLC_MODE_MAN_NORM: begin
                next_ref   = ref_select[1:0];
                next_valid = ref_ok(ref_qualified, ref_select);
                next_state = next_valid ? DMLC_ST_LOCKED : DMLC_ST_HOLD;
            end
            `DMLC_MODE_MAN_HOLD: begin
                next_valid = 1'b0;
                next_state = DMLC_ST_HOLD;
            end
            `DMLC_MODE_MAN_FREE: begin
                next_valid = 1'b0;
                next_state = DMLC_ST_FREE;
            end
            `DMLC_MODE_AUTO: begin
                // non-revertive keeps a healthy reference; revertive returns
                // to the best one as soon as it qualifies again
                if (active_valid && ref_qualified[active_ref] &&
                    !(dpll_holdover_switch_control[`DMLC_F_REVERT] && best_ref < active_ref)) begin
                    next_ref = active_ref;
                end else begin
                    next_ref = best_ref;
                end
                next_valid = any_qual;
                next_state = any_qual ? DMLC_ST_LOCKED : DMLC_ST_HOLD;
            end
            `DMLC_MODE_PKT_CLIENT: begin
                next_valid = 1'b0;
                next_state = DMLC_ST_SWCL;
            end
            default: ; // undefined codes leave the loop where it is
        endcase
    end

    // loop state and reference registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_state   <= DMLC_ST_FREE;
            active_ref   <= 2'h0;
            active_valid <= 1'b0;
            switch_start <= 1'b0;
        end else if (clk_en) begin
            loop_state   <= next_state;
            active_ref   <= next_ref;
            active_valid <= next_valid;
            switch_start <= next_valid && active_valid && (next_ref != active_ref);
        end
    end

    // mode-derived controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_switch_en <= 1'b0;
            dco_sw_ctrl    <= 1'b0;
        end else if (clk_en) begin
            auto_switch_en <= (dpll_operating_mode_select == `DMLC_MODE_AUTO);
            dco_sw_ctrl    <= (dpll_operating_mode_select == `DMLC_MODE_PKT_CLIENT);
        end
    end

    // rate of the reference in use, for the bandwidth clamp
    assign act_2k = next_valid && ref_is_2khz[next_ref];
    assign act_8k = next_valid && ref_is_8khz[next_ref];

    // slow references cannot carry a wide loop, so the wide codes are clamped
    always_comb begin
        unique case (dpll_loop_control[`DMLC_F_BW_HI:`DMLC_F_BW_LO])
            `DMLC_BW_28HZ:  next_bw = act_2k ? DMLC_EBW_14HZ : DMLC_EBW_28HZ;
            `DMLC_BW_890HZ: next_bw = act_2k ? DMLC_EBW_14HZ :
                                      act_8k ? DMLC_EBW_56HZ : DMLC_EBW_890HZ;
            3'h7:           next_bw = DMLC_EBW_RSVD;
            default:        next_bw = dmlc_bw_t'({1'b0, dpll_loop_control[3:1]});
        endcase
    end

    // field outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_bw_eff            <= DMLC_EBW_FAST;
            phase_slope_limit_sel  <= 2'h3;
            hitless_switch_ctrl    <= 1'b0;
            revert_en              <= 1'b0;
            freq_offset_en         <= 1'b0;
            holdover_postfilter_bw <= 2'h0;
        end else if (clk_en) begin
            loop_bw_eff            <= next_bw;
            phase_slope_limit_sel  <= dpll_loop_control[`DMLC_F_SLOPE_HI:`DMLC_F_SLOPE_LO];
            hitless_switch_ctrl    <= dpll_loop_control[`DMLC_F_HITLESS];
            revert_en              <= dpll_holdover_switch_control[`DMLC_F_REVERT];
            freq_offset_en         <= dpll_holdover_switch_control[`DMLC_F_FOFS];
            holdover_postfilter_bw <= dpll_holdover_switch_control[7:6];
        end
    end

    // holdover value refreshed periodically while tracking
    dmlc_hold_timer #(
        .CYC0 (HOLD_CYC0),
        .CYC1 (HOLD_CYC1),
        .CYC2 (HOLD_CYC2),
        .CYC3 (HOLD_CYC3)
    ) u_hold_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .run     (loop_state == DMLC_ST_LOCKED),
        .sel     (dpll_holdover_switch_control[`DMLC_F_HUPD_HI:`DMLC_F_HUPD_LO]),
        .tick    (holdover_update)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_BW_WRITE: assert property (
        wr_fire && reg_idx == `DMLC_IDX_LOOP |=>
            dpll_loop_control[3:1] == $past(pwdata[3:1]))
        else $error("bandwidth field not stored");
    AST_CLAMP_28: assert property (
        clk_en && dpll_loop_control[3:1] == `DMLC_BW_28HZ && act_2k |=>
            loop_bw_eff == DMLC_EBW_14HZ)
        else $error("28 Hz not clamped for 2 kHz reference");
    AST_CLAMP_890_8K: assert property (
        clk_en && dpll_loop_control[3:1] == `DMLC_BW_890HZ && !act_2k && act_8k |=>
            loop_bw_eff == DMLC_EBW_56HZ)
        else $error("890 Hz not clamped to 56 Hz");
    AST_MAN_FAIL: assert property (
        clk_en && dpll_operating_mode_select == `DMLC_MODE_MAN_NORM &&
            !ref_ok(ref_qualified, ref_select) |=> loop_state == DMLC_ST_HOLD)
        else $error("manual normal did not enter holdover");
    AST_MAN_HOLD: assert property (
        clk_en && dpll_operating_mode_select == `DMLC_MODE_MAN_HOLD ##1
            clk_en && dpll_operating_mode_select == `DMLC_MODE_MAN_HOLD |=>
            loop_state == DMLC_ST_HOLD && !auto_switch_en)
        else $error("manual holdover left holdover");
    AST_MAN_FREE: assert property (
        clk_en && dpll_operating_mode_select == `DMLC_MODE_MAN_FREE |=>
            loop_state == DMLC_ST_FREE)
        else $error("manual free-run not free-running");
    AST_AUTO_BEST: assert property (
        clk_en && dpll_operating_mode_select == `DMLC_MODE_AUTO && !active_valid &&
            any_qual |=> active_ref == $past(best_ref) && loop_state == DMLC_ST_LOCKED)
        else $error("automatic mode missed best reference");
    AST_AUTO_SWITCH: assert property (
        clk_en && dpll_operating_mode_select == `DMLC_MODE_AUTO && active_valid &&
            !ref_qualified[active_ref] && any_qual |=>
            switch_start && active_ref != $past(active_ref))
        else $error("failed reference not switched");
    AST_AUTO_NONE: assert property (
        clk_en && dpll_operating_mode_select == `DMLC_MODE_AUTO && !any_qual |=>
            loop_state == DMLC_ST_HOLD && !active_valid)
        else $error("no reference but not in holdover");
    AST_PKT_CLIENT: assert property (
        clk_en && dpll_operating_mode_select == `DMLC_MODE_PKT_CLIENT |=>
            dco_sw_ctrl && loop_state == DMLC_ST_SWCL)
        else $error("oscillator not handed to software");
endmodule : dmlc_top

/* sim/dmlc_ref_model.sv */
/*
 * model of the reference sources seen through their monitors: per-reference
 * qualified flag and 2 kHz / 8 kHz rate flags, all levels.
 * assumes: the bench calls set_refs to change the sources; flags move only
 * just after a rising edge of pclk, as a synchronous monitor would.
 */
module dmlc_ref_model (
    // clock
    input  wire logic       pclk,
    // monitor flags toward the block
    output logic      [2:0] qualified,
    output logic      [2:0] rate_2khz,
    output logic      [2:0] rate_8khz
);
    timeunit 1ns;
    timeprecision 1ps;

    // all sources present and of no special rate from time zero
    initial begin
        qualified = 3'h7;
        rate_2khz = 3'h0;
        rate_8khz = 3'h0;
    end

    // one change of all sources at one edge, so no half-updated flag set is seen
    task automatic set_refs(input logic [2:0] q, input logic [2:0] r2, input logic [2:0] r8);
        @(posedge pclk);
        qualified <= q;
        rate_2khz <= r2;
        rate_8khz <= r8;
    endtask : set_refs
endmodule : dmlc_ref_model

/* sim/dmlc_tb.sv */
/*
 * self-checking bench of the loop mode and control block: APB register
 * accesses, field outputs, bandwidth clamping, holdover refresh period and
 * the operating modes against the reference source model.
 * assumes: holdover periods shortened to 5, 7, 9 and 11 cycles.
 */
module tb
    import dmlc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_LOOP = 12'h074;
    localparam logic [11:0] A_HOLD = 12'h078;
    localparam logic [11:0] A_MODE = 12'h07C;
    localparam logic [11:0] A_REF  = 12'h080;
    localparam int          CYC[4] = '{5, 7, 9, 11};

    // stimulus and observed signals
    logic        pclk, presetn, clk_en, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        pready, pslverr, erv;
    logic [2:0]  qual, r2k, r8k;
    dmlc_state_t loop_state;
    dmlc_bw_t    loop_bw_eff;
    logic [1:0]  slope, pfbw, active_ref;
    logic        hitless, revert_en, fofs_en, upd, auto_en, dco_sw, act_valid, sw_start;
    int          err_total, comparisons, i, k;

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    dmlc_ref_model ref_u (.pclk(pclk), .qualified(qual), .rate_2khz(r2k), .rate_8khz(r8k));

    dmlc_top #(.HOLD_CYC0(5), .HOLD_CYC1(7), .HOLD_CYC2(9), .HOLD_CYC3(11)) dut_u (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_qualified(qual), .ref_is_2khz(r2k), .ref_is_8khz(r8k),
        .loop_state(loop_state), .loop_bw_eff(loop_bw_eff), .phase_slope_limit_sel(slope),
        .hitless_switch_ctrl(hitless), .revert_en(revert_en), .freq_offset_en(fofs_en),
        .holdover_postfilter_bw(pfbw), .holdover_update(upd), .auto_switch_en(auto_en),
        .dco_sw_ctrl(dco_sw), .active_ref(active_ref), .active_valid(act_valid),
        .switch_start(sw_start));

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // one APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rdata, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d}, rdv, erv);
        chk("write_pslverr", 32'h0, 32'(erv));
    endtask : wr

    task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, rdv, erv);
        chk(n, {24'h000000, e}, rdv);
    endtask : rd

    // field copies and the loop state and reference outputs all lag the register by one edge
    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle

    // cycles until the next refresh pulse, sampled once edge updates have landed
    task automatic wait_upd(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (upd !== 1'b1 && n < 100);
    endtask : wait_upd

    function automatic logic [31:0] exp_bw(input int c, input int rt);
        if (c == 4 && rt == 1) return 32'h3;
        if (c == 5) return (rt == 1) ? 32'h3 : ((rt == 2) ? 32'h7 : 32'h5);
        return 32'(c);
    endfunction : exp_bw

    // hang guard: the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        finish_test;
    end

    initial begin
        err_total = 0;
        comparisons = 0;
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // reset values of the registers and their field outputs
        rd("loop_reg_reset", A_LOOP, 8'h3C);
        rd("hold_reg_reset", A_HOLD, 8'h04);
        rd("mode_reg_reset", A_MODE, 8'h03);
        settle;
        chk("slope_reset", 32'h3, 32'(slope));
        chk("bw_reset", 32'h6, 32'(loop_bw_eff));
        chk("hitless_reset", 32'h0, 32'(hitless));
        chk("fofs_reset", 32'h0, 32'(fofs_en));
        $display("test reset done");
        // bandwidth codes 0 to 6 under each reference rate
        for (i = 0; i < 21; i++) begin
            ref_u.set_refs(3'h7, (i / 7 == 1) ? 3'h7 : 3'h0, (i / 7 == 2) ? 3'h7 : 3'h0);
            wr(A_LOOP, {2'b00, 2'b11, 3'(i % 7), 1'b0});
            settle;
            chk("loop_bw_eff", exp_bw(i % 7, i / 7), 32'(loop_bw_eff));
        end
        ref_u.set_refs(3'h7, 3'h0, 3'h0);
        $display("test bandwidth done");
        // slope limit and hitless control, with read-back
        for (i = 0; i < 4; i++) begin
            wr(A_LOOP, {2'b00, 2'(i), 3'b110, i[0]});
            settle;
            chk("slope", 32'(i), 32'(slope));
            chk("hitless", 32'(i[0]), 32'(hitless));
            rd("loop_reg", A_LOOP, {2'b00, 2'(i), 3'b110, i[0]});
        end
        $display("test slope done");
        // holdover and switching fields, written while free-running
        wr(A_MODE, 8'h02);
        for (i = 0; i < 4; i++) begin
            wr(A_HOLD, {2'(i), 2'(3 - i), 2'b01, 2'(i)});
            settle;
            chk("free_state", 32'(DMLC_ST_FREE), 32'(loop_state));
            chk("revert_en", 32'(i[0]), 32'(revert_en));
            chk("fofs_en", 32'(i[1]), 32'(fofs_en));
            chk("postfilter", 32'(i), 32'(pfbw));
            rd("hold_reg", A_HOLD, {2'(i), 2'(3 - i), 2'b01, 2'(i)});
        end
        $display("test holdover fields done");
        // refresh period of each code while locked in automatic mode
        wr(A_MODE, 8'h03);
        for (i = 0; i < 4; i++) begin
            wr(A_HOLD, {2'b00, 2'(i), 2'b01, 2'b00});
            wait_upd(k);
            wait_upd(k);
            wait_upd(k);
            chk("update_period", 32'(CYC[i]), 32'(k));
        end
        $display("test update period done");
        // automatic mode: lock, switch on failure, revert, holdover
        settle;
        chk("auto_state", 32'(DMLC_ST_LOCKED), 32'(loop_state));
        chk("auto_ref", 32'h0, 32'(active_ref));
        chk("auto_en", 32'h1, 32'(auto_en));
        ref_u.set_refs(3'h6, 3'h0, 3'h0);
        @(posedge pclk);
        #1;
        chk("switch_start", 32'h1, 32'(sw_start));
        chk("new_ref", 32'h1, 32'(active_ref));
        @(posedge pclk);
        #1;
        chk("switch_pulse", 32'h0, 32'(sw_start));
        rd("refsel_auto", A_REF, 8'h01);
        wr(A_HOLD, 8'h05);
        ref_u.set_refs(3'h7, 3'h0, 3'h0);
        settle;
        chk("revert_ref", 32'h0, 32'(active_ref));
        wr(A_HOLD, 8'h04);
        ref_u.set_refs(3'h0, 3'h0, 3'h0);
        settle;
        chk("none_state", 32'(DMLC_ST_HOLD), 32'(loop_state));
        chk("none_valid", 32'h0, 32'(act_valid));
        $display("test automatic done");
        // manual modes and packet client
        ref_u.set_refs(3'h7, 3'h0, 3'h0);
        wr(A_MODE, 8'h01);
        settle;
        chk("hold_state", 32'(DMLC_ST_HOLD), 32'(loop_state));
        chk("hold_auto_en", 32'h0, 32'(auto_en));
        wr(A_MODE, 8'h04);
        settle;
        chk("client_state", 32'(DMLC_ST_SWCL), 32'(loop_state));
        chk("dco_sw_ctrl", 32'h1, 32'(dco_sw));
        wr(A_MODE, 8'h00);
        wr(A_REF, 8'h02);
        settle;
        chk("man_state", 32'(DMLC_ST_LOCKED), 32'(loop_state));
        chk("man_ref", 32'h2, 32'(active_ref));
        chk("man_auto_en", 32'h0, 32'(auto_en));
        rd("refsel_man", A_REF, 8'h02);
        ref_u.set_refs(3'h3, 3'h0, 3'h0);
        settle;
        chk("man_fail", 32'(DMLC_ST_HOLD), 32'(loop_state));
        // clock enable low freezes the loop even when the chosen source returns
        @(posedge pclk);
        clk_en <= 1'b0;
        ref_u.set_refs(3'h7, 3'h0, 3'h0);
        settle;
        chk("frozen_state", 32'(DMLC_ST_HOLD), 32'(loop_state));
        @(posedge pclk);
        clk_en <= 1'b1;
        settle;
        chk("thawed_state", 32'(DMLC_ST_LOCKED), 32'(loop_state));
        $display("test manual done");
        // unmapped address is refused
        apb(1'b1, 12'h0FC, 32'h000000FF, rdv, erv);
        chk("unmapped_wr_err", 32'h1, 32'(erv));
        apb(1'b0, 12'h0FC, 32'h0, rdv, erv);
        chk("unmapped_rd_err", 32'h1, 32'(erv));
        chk("unmapped_rd", 32'h0, rdv);
        wr(A_MODE, 8'h03);
        $display("test unmapped done");
        finish_test;
    end
endmodule : tb
